// >>> bench/bsr_apb_master.sv
// APB master model that stands on the bus side of the register bank
`default_nettype none
module bsr_apb_master
(
    input wire logic clk,
    output logic [31:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus after time zero
    initial
    begin
        paddr = 32'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
    end
    // One transfer: setup, access, bounded wait for ready
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err, output logic ok);
        ok = 1'b0;
        rd = 32'h0;
        err = 1'b0;
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= wd; // Caller keeps reserved bits zero
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n < 16 && !ok; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
            begin
                rd = prdata;
                err = pslverr;
                ok = 1'b1;
            end
        end
        // Release; address and data no longer hold old values
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~wd;
    endtask
endmodule
`default_nettype wire

// >>> bench/tb_board_system_register_bank.sv
// Self-checking bench for the board system register bank
`default_nettype none
module tb_board_system_register_bank
    import bsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned DIV = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic board_reset_n = 1'b1;
    logic [7:0] cfg_sw = 8'h3c;
    logic present = 1'b1;
    logic [31:0] paddr, pwdata, prdata, rv, rv2;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] leds;
    logic event_out;
    int fail_count = 0;
    int n_tests = 0;

    bsr_top #(.SLOW_TICK_DIV(DIV)) bsr_top_inst (
        .clk(clk), .rst_n(rst_n), .board_reset_n(board_reset_n),
        .configured_switch_setting(cfg_sw), .daughter_present(present),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .user_led_states(leds),
        .daughter_event_out(event_out));
    bsr_apb_master bsr_apb_master_inst (
        .clk(clk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // Clock at 50 ns period
    initial
    begin
        forever #25 clk = ~clk;
    end
    // Verdict and end of run
    task automatic final_report();
        $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Word comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Bus access; a hung transfer ends the run
    task automatic acc(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        logic ok;
        bsr_apb_master_inst.xfer(w, a, wd, rd, err, ok);
        if (!ok)
        begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic wr(input logic [11:0] off, input logic [31:0] d);
        logic [31:0] r;
        logic er;
        acc(1'b1, BSR_BASE_ADDR + {20'h0, off}, d, r, er);
        chk({31'h0, er}, 32'h0);
    endtask
    task automatic rd(input logic [11:0] off, output logic [31:0] d);
        logic er;
        acc(1'b0, BSR_BASE_ADDR + {20'h0, off}, 32'h0, d, er);
        chk({31'h0, er}, 32'h0);
    endtask
    // Values right after power-on
    task automatic t_reset();
        chk({24'h0, leds}, 32'h0);
        rd(OFF_SOFT_CFG, rv);
        chk({24'h0, rv[7:0]}, {24'h0, cfg_sw});
        rd(OFF_MISC, rv);
        chk(rv, 32'h00002000);
    endtask
    // LED and config switch read-write
    task automatic t_led();
        wr(OFF_USER_LED, 32'ha5);
        chk({24'h0, leds}, 32'ha5);
        rd(OFF_USER_LED, rv);
        chk({24'h0, rv[7:0]}, 32'ha5);
        wr(OFF_SOFT_CFG, 32'h5a);
        rd(OFF_SOFT_CFG, rv);
        chk({24'h0, rv[7:0]}, 32'h5a);
    endtask
    // Unmapped offset and address outside the base
    task automatic t_err();
        acc(1'b0, BSR_BASE_ADDR + 32'h4, 32'h0, rv, e);
        chk({31'h0, e}, 32'h1);
        chk(rv, 32'h0);
        acc(1'b1, BSR_BASE_ADDR + 32'h1000, 32'h0, rv, e);
        chk({31'h0, e}, 32'h1);
    endtask
    // Set and clear on both flag registers
    task automatic t_flags();
        logic [11:0] b;
        for (int i = 0; i < 2; i++)
        begin
            b = (i == 0) ? OFF_VOL_FLAGS : OFF_NV_FLAGS;
            wr(b, 32'hf0f000ff);
            wr(b, 32'h0000ff00);
            wr(b + 12'h4, 32'h00f000f0);
            rd(b, rv);
            chk(rv, 32'hf000ff0f);
            rd(b + 12'h4, rv);
            chk(rv, 32'h0);
        end
    endtask
    // Fast counter per cycle, read-only; slow counter per divider
    task automatic t_count();
        logic [31:0] d;
        rd(OFF_FAST_TICK, rv);
        rd(OFF_FAST_TICK, rv2);
        chk(rv2 - rv, 32'h4);
        wr(OFF_FAST_TICK, 32'h0);
        rd(OFF_FAST_TICK, rv);
        chk(rv - rv2, 32'h8);
        rd(OFF_SLOW_TICK, rv);
        repeat (80) @(posedge clk);
        rd(OFF_SLOW_TICK, rv2);
        d = rv2 - rv;
        chk({31'h0, d == 32'd10 || d == 32'd11}, 32'h1);
    endtask
    // Event bit drives the output; presence shows in bit 13
    task automatic t_misc();
        present <= 1'b0;
        repeat (6) @(posedge clk);
        wr(OFF_MISC, 32'h00080000);
        chk({31'h0, event_out}, 32'h1);
        rd(OFF_MISC, rv);
        chk(rv, 32'h00080000);
        wr(OFF_MISC, 32'h0);
        chk({31'h0, event_out}, 32'h0);
        present <= 1'b1;
        repeat (6) @(posedge clk);
        rd(OFF_MISC, rv);
        chk(rv, 32'h00002000);
    endtask
    // Push-button reset: volatile state cleared, persistent kept
    task automatic t_board();
        wr(OFF_VOL_FLAGS, 32'h11);
        wr(OFF_NV_FLAGS, 32'h22);
        wr(OFF_MISC, 32'h00080000);
        board_reset_n <= 1'b0;
        cfg_sw <= 8'hc3;
        repeat (6) @(posedge clk);
        chk({23'h0, event_out, leds}, 32'h0);
        board_reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        rd(OFF_VOL_FLAGS, rv);
        chk(rv, 32'h0);
        rd(OFF_NV_FLAGS, rv);
        chk(rv, 32'hf000ff2f);
        rd(OFF_SOFT_CFG, rv);
        chk({24'h0, rv[7:0]}, 32'hc3);
        rd(OFF_FAST_TICK, rv);
        chk({31'h0, rv < 32'd32}, 32'h1);
        rd(OFF_USER_LED, rv);
        chk({24'h0, rv[7:0]}, 32'h0);
        rd(OFF_SLOW_TICK, rv);
        chk({31'h0, rv > 32'd0 && rv < 32'd6}, 32'h1);
    endtask
    // Power-on reset clears persistent flags and LEDs
    task automatic t_por();
        wr(OFF_USER_LED, 32'h3c);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk({24'h0, leds}, 32'h0);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        rd(OFF_NV_FLAGS, rv);
        chk(rv, 32'h0);
        rd(OFF_SOFT_CFG, rv);
        chk({24'h0, rv[7:0]}, 32'hc3);
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        t_reset();
        t_led();
        t_err();
        t_flags();
        t_count();
        t_misc();
        t_board();
        t_por();
        final_report();
    end
endmodule
`default_nettype wire

// >>> hw/bsr_pkg.sv
// Constants shared by the board system register bank
`default_nettype none
package bsr_pkg;
    // Bus placement and register byte offsets
    localparam logic [31:0] BSR_BASE_ADDR = 32'h1c010000;
    localparam logic [11:0] OFF_USER_LED = 12'h008;
    localparam logic [11:0] OFF_SLOW_TICK = 12'h024;
    localparam logic [11:0] OFF_VOL_FLAGS = 12'h030;
    localparam logic [11:0] OFF_VOL_CLEAR = 12'h034;
    localparam logic [11:0] OFF_NV_FLAGS = 12'h038;
    localparam logic [11:0] OFF_NV_CLEAR = 12'h03c;
    localparam logic [11:0] OFF_SOFT_CFG = 12'h058;
    localparam logic [11:0] OFF_FAST_TICK = 12'h05c;
    localparam logic [11:0] OFF_MISC = 12'h060;
    // Field positions inside the miscellaneous register
    localparam int MISC_EVENT_BIT = 19;
    localparam int MISC_PRESENT_BIT = 13;
    // Values after reset
    localparam logic [7:0] LED_RESET = 8'h00;
    localparam logic [31:0] FLAGS_RESET = 32'h00000000;
    localparam logic [31:0] COUNT_RESET = 32'h00000000;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Slow tick timing: 100 Hz period in ns, clock period in ns
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SLOW_PERIOD_NS = 10000000;
    localparam int unsigned SLOW_DIV = SLOW_PERIOD_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// >>> hw/bsr_tick_gen.sv
// Divider producing the one-cycle 100 Hz tick strobe
`default_nettype none
module bsr_tick_gen
    import bsr_pkg::*;
#(
    parameter int unsigned DIV = SLOW_DIV
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    output logic tick
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tick_q;
    logic tick_d;

    // Count to DIV-1, then strobe and restart
    always_comb
    begin
        cnt_d = cnt_q + 32'h1;
        tick_d = 1'b0;
        if (clear)
        begin
            cnt_d = COUNT_RESET;
        end
        else if (cnt_q == 32'(DIV - 1))
        begin
            cnt_d = COUNT_RESET;
            tick_d = 1'b1;
        end
    end

    // Divider state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule
`default_nettype wire

// >>> hw/bsr_top.sv
// Board system register bank with APB slave port
`default_nettype none
// Summary of operation
// - APB slave at fixed base, one 32-bit register per word offset.
// - All user LEDs off while reset is applied.
// - Eight read-write LED bits in [7:0]; one lights, reads give state.
// - Slow 32-bit counter advances at 100 Hz divided from board clock.
// - Slow counter holds 100 Hz ticks since last board reset.
// - Fast 32-bit read-only counter increments every clock cycle.
// - Fast counter is zero during board reset, then resumes.
// - Flag registers read back and also act as set registers; clear registers write-only.
// - Set register write sets flags at one bits, others unchanged.
// - Clear register write clears flags at one bits, others unchanged.
// - Volatile flags cleared by push-button reset.
// - Persistent flags survive push-button reset; cleared at power-on.
// - Soft config switches load from configured setting at reset.
// - Soft config switch contents steer no board behaviour.
// - Misc bit 19 read-write, bit 13 read-only, rest read zero.
// - Daughter event output driven from stored misc bit 19.
// - Misc bit 13 reads one when daughterboard fitted, else zero.
module bsr_top
    import bsr_pkg::*;
#(
    parameter int unsigned SLOW_TICK_DIV = SLOW_DIV
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic board_reset_n,
    input wire logic [7:0] configured_switch_setting,
    input wire logic daughter_present,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] user_led_states,
    output logic daughter_event_out
);
    // Pin synchronisers: bit 0 board reset, bit 1 daughter presence
    logic [1:0] sy1_q;
    logic [1:0] sy2_q;
    logic [1:0] sy3_q;
    logic brd_rst_q;
    logic brd_rst_d;
    logic present_q;
    logic present_d;

    // APB answer state
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    // Register contents
    logic [7:0] led_q;
    logic [7:0] led_d;
    logic [31:0] vflag_q;
    logic [31:0] vflag_d;
    logic [31:0] nvflag_q;
    logic [31:0] nvflag_d;
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic event_q;
    logic event_d;
    logic [31:0] slow_q;
    logic [31:0] slow_d;
    logic [31:0] fast_q;
    logic [31:0] fast_d;

    // Decode helpers
    logic in_base;
    logic [11:0] off;
    logic mapped;
    logic acc;
    logic wr_fire;
    logic rd_fire;
    logic slow_tick;

    // Slow tick divider, held in step with board reset
    bsr_tick_gen #(
        .DIV(SLOW_TICK_DIV)
    ) bsr_tick_gen_inst (
        .clk(clk),
        .rst_n(rst_n),
        .clear(brd_rst_q),
        .tick(slow_tick)
    );

    // Three-stage synchronisers for both pins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sy1_q <= 2'h0;
            sy2_q <= 2'h0;
            sy3_q <= 2'h0;
        end
        else
        begin
            sy1_q <= {daughter_present, board_reset_n};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
        end
    end

    // Filtered levels: accepted once stages two and three agree
    always_comb
    begin
        brd_rst_d = brd_rst_q;
        present_d = present_q;
        if (sy2_q[0] == sy3_q[0])
        begin
            brd_rst_d = ~sy3_q[0];
        end
        if (sy2_q[1] == sy3_q[1])
        begin
            present_d = sy3_q[1];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            brd_rst_q <= 1'b1;
            present_q <= 1'b0;
        end
        else
        begin
            brd_rst_q <= brd_rst_d;
            present_q <= present_d;
        end
    end

    // Address decode against the bank base
    always_comb
    begin
        in_base = (paddr[31:12] == BSR_BASE_ADDR[31:12]);
        off = paddr[11:0];
        case (off)
            OFF_USER_LED, OFF_SLOW_TICK, OFF_VOL_FLAGS, OFF_VOL_CLEAR,
            OFF_NV_FLAGS, OFF_NV_CLEAR, OFF_SOFT_CFG, OFF_FAST_TICK,
            OFF_MISC: mapped = in_base;
            default: mapped = 1'b0;
        endcase
        acc = psel & penable & ~pready_q;
        wr_fire = acc & pwrite & mapped;
        rd_fire = acc & ~pwrite & mapped;
    end

    // APB answer: one wait state, read data chosen by offset
    always_comb
    begin
        pready_d = acc;
        pslverr_d = acc & ~mapped;
        prdata_d = 32'h0;
        if (rd_fire)
        begin
            case (off)
                OFF_USER_LED: prdata_d = {24'h0, led_q};
                OFF_SLOW_TICK: prdata_d = slow_q;
                OFF_VOL_FLAGS: prdata_d = vflag_q;
                OFF_NV_FLAGS: prdata_d = nvflag_q;
                OFF_SOFT_CFG: prdata_d = {24'h0, cfg_q};
                OFF_FAST_TICK: prdata_d = fast_q;
                OFF_MISC:
                begin
                    prdata_d[MISC_EVENT_BIT] = event_q;
                    prdata_d[MISC_PRESENT_BIT] = present_q;
                end
                default: prdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else
        begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // Register updates: writes, counters, then board reset on top
    always_comb
    begin
        led_d = led_q;
        vflag_d = vflag_q;
        nvflag_d = nvflag_q;
        cfg_d = cfg_q;
        event_d = event_q;
        fast_d = fast_q + 32'h1;
        slow_d = slow_tick ? slow_q + 32'h1 : slow_q;
        if (wr_fire)
        begin
            case (off)
                OFF_USER_LED: led_d = pwdata[7:0];
                OFF_VOL_FLAGS: vflag_d = vflag_q | pwdata;
                OFF_VOL_CLEAR: vflag_d = vflag_q & ~pwdata;
                OFF_NV_FLAGS: nvflag_d = nvflag_q | pwdata;
                OFF_NV_CLEAR: nvflag_d = nvflag_q & ~pwdata;
                OFF_SOFT_CFG: cfg_d = pwdata[7:0];
                OFF_MISC: event_d = pwdata[MISC_EVENT_BIT];
                default: event_d = event_q;
            endcase
        end
        // Push-button reset; persistent flags deliberately untouched
        if (brd_rst_q)
        begin
            led_d = LED_RESET;
            vflag_d = FLAGS_RESET;
            fast_d = COUNT_RESET;
            slow_d = COUNT_RESET;
            event_d = 1'b0;
            cfg_d = configured_switch_setting;
        end
    end

    // Cfg switches are only stored and read back, never decoded
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            led_q <= LED_RESET;
            vflag_q <= FLAGS_RESET;
            nvflag_q <= FLAGS_RESET;
            cfg_q <= CFG_RESET;
            event_q <= 1'b0;
            slow_q <= COUNT_RESET;
            fast_q <= COUNT_RESET;
        end
        else
        begin
            led_q <= led_d;
            vflag_q <= vflag_d;
            nvflag_q <= nvflag_d;
            cfg_q <= cfg_d;
            event_q <= event_d;
            slow_q <= slow_d;
            fast_q <= fast_d;
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign user_led_states = led_q;
    assign daughter_event_out = event_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_led_reset_off: assert property (
        brd_rst_q |=> user_led_states == 8'h0)
        else $error("LEDs not off after board reset");

    a_led_write_back: assert property (
        wr_fire && off == OFF_USER_LED && !brd_rst_q
        |=> pready && user_led_states == $past(pwdata[7:0]))
        else $error("LED write not applied");

    a_fast_increment: assert property (
        !brd_rst_q |=> fast_q == $past(fast_q) + 32'h1)
        else $error("Fast counter did not step by one");

    a_fast_reset_zero: assert property (
        brd_rst_q ##1 !brd_rst_q |-> fast_q == 32'h0 ##1 fast_q == 32'h1)
        else $error("Fast counter not restarted from zero");

    a_slow_hold_step: assert property (
        !brd_rst_q |=> slow_q == $past(slow_q) + {31'h0, $past(slow_tick)})
        else $error("Slow counter moved without a tick");

    a_flag_set_or: assert property (
        wr_fire && off == OFF_VOL_FLAGS && !brd_rst_q
        |=> vflag_q == ($past(vflag_q) | $past(pwdata)))
        else $error("Volatile set write wrong");

    a_nv_clear_and: assert property (
        wr_fire && off == OFF_NV_CLEAR
        |=> nvflag_q == ($past(nvflag_q) & ~$past(pwdata)))
        else $error("Persistent clear write wrong");

    a_vol_reset_clear: assert property (
        brd_rst_q |=> vflag_q == 32'h0)
        else $error("Volatile flags survived board reset");

    a_nv_keep_reset: assert property (
        brd_rst_q && !(wr_fire && (off == OFF_NV_FLAGS
        || off == OFF_NV_CLEAR)) |=> $stable(nvflag_q))
        else $error("Persistent flags changed in board reset");

    a_cfg_load_reset: assert property (
        rst_n && brd_rst_q |=> cfg_q == $past(configured_switch_setting))
        else $error("Config switches not loaded at reset");

    a_misc_read_data: assert property (
        rd_fire && off == OFF_MISC |=> pready && prdata ==
        {12'h0, $past(event_q), 5'h0, $past(present_q), 13'h0})
        else $error("Misc read value wrong");

    a_event_from_write: assert property (
        wr_fire && off == OFF_MISC && !brd_rst_q
        |=> daughter_event_out == $past(pwdata[MISC_EVENT_BIT]))
        else $error("Event output does not follow bit 19");

    a_bus_answer: assert property (
        acc |=> pready && pslverr == !$past(mapped))
        else $error("Bus answer missing or error flag wrong");

    a_ready_one_cycle: assert property (
        pready |=> !pready)
        else $error("Ready held longer than one cycle");

    a_error_read_zero: assert property (
        acc && !mapped |=> prdata == 32'h0)
        else $error("Refused access returned data");

    a_clear_reads_zero: assert property (
        rd_fire && (off == OFF_VOL_CLEAR || off == OFF_NV_CLEAR)
        |=> prdata == 32'h0)
        else $error("Write-only register read back data");

    a_nv_set_or: assert property (
        wr_fire && off == OFF_NV_FLAGS
        |=> nvflag_q == ($past(nvflag_q) | $past(pwdata)))
        else $error("Persistent set write wrong");

    a_vol_clear_and: assert property (
        wr_fire && off == OFF_VOL_CLEAR && !brd_rst_q
        |=> vflag_q == ($past(vflag_q) & ~$past(pwdata)))
        else $error("Volatile clear write wrong");

    a_slow_reset_zero: assert property (
        rst_n && brd_rst_q |=> slow_q == 32'h0)
        else $error("Slow counter not cleared by board reset");
endmodule
`default_nettype wire
